// ### pkg/rstc_pkg.sv
// rstc_pkg: constants for the rs-485 transceiver direction control block.
// assumes one uart clock domain; mode byte written through the scratch port.
package rstc_pkg;

  // transceiver control modes, as the control byte encodes them
  typedef enum logic [1:0] {
    RSTC_MODE_FOUR_WIRE = 2'b00,
    RSTC_MODE_DTR_ECHO  = 2'b01,
    RSTC_MODE_DTR_CTRL  = 2'b10,
    RSTC_MODE_AUTO      = 2'b11
  } rstc_mode_e;

  localparam logic [2:0] RSTC_MODE_OFFSET = 3'h7;
  localparam logic [1:0] RSTC_MODE_RESET  = 2'h0;

  // fifo shape and default trigger levels
  localparam int unsigned RSTC_FIFO_DEPTH   = 16;
  localparam int unsigned RSTC_DATA_W       = 8;
  localparam logic [4:0]  RSTC_RX_TRIG_RST  = 5'h01;
  localparam logic [4:0]  RSTC_TX_TRIG_RST  = 5'h10;

  // serial frame: start, 8 data, one stop; bit time in uart clocks
  localparam int unsigned RSTC_FRAME_BITS   = 10;
  localparam int unsigned RSTC_BIT_CLKS     = 16;

endpackage

// ### src/rstc_fifo.sv
// rstc_fifo: small synchronous fifo used for both uart directions.
// assumes single clock; read data comes from a register.
`timescale 1ns/1ps
`default_nettype none
module rstc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_clear,
  input  wire logic                     i_wr,
  input  wire logic [WIDTH-1:0]         i_wdata,
  input  wire logic                     i_rd,
  output logic      [WIDTH-1:0]         o_rdata,
  output logic      [$clog2(DEPTH):0]   o_count,
  output logic                          o_full,
  output logic                          o_empty
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic             do_wr;
  logic             do_rd;

  assign o_full  = (o_count == (AW+1)'(DEPTH));
  assign o_empty = (o_count == '0);
  assign do_wr   = i_wr && !o_full;
  assign do_rd   = i_rd && !o_empty;

  always_ff @(posedge i_mclk) begin
    if (do_wr) begin
      mem[wptr] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr    <= '0;
      rptr    <= '0;
      o_count <= '0;
      o_rdata <= '0;
    end else if (i_clear) begin
      wptr    <= '0;
      rptr    <= '0;
      o_count <= '0;
    end else begin
      if (do_wr) begin
        wptr <= wptr + 1'b1;
      end
      if (do_rd) begin
        o_rdata <= mem[rptr];
        rptr    <= rptr + 1'b1;
      end
      o_count <= o_count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

// ### src/rstc_top.sv
// rstc_top: rs-485 transceiver direction control with uart fifos.
// assumes host writes on a simple 3-bit port bus; one uart clock.
`timescale 1ns/1ps
`default_nettype none
module rstc_top #(
  parameter int unsigned DEPTH    = rstc_pkg::RSTC_FIFO_DEPTH,
  parameter int unsigned BIT_CLKS = rstc_pkg::RSTC_BIT_CLKS,
  parameter bit          IS_RS485 = 1'b1
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_wr,
  input  wire logic [2:0]             i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_dtr_n,
  input  wire logic                   i_fifo_en,
  input  wire logic [4:0]             i_rx_trig,
  input  wire logic [4:0]             i_tx_trig,
  input  wire logic                   i_tx_push,
  input  wire logic [7:0]             i_tx_data,
  input  wire logic                   i_rx_pop,
  input  wire logic                   i_rxd,
  output logic                        o_txd,
  output logic                        o_drv_en,
  output logic                        o_rcv_en,
  output logic [1:0]                  o_mode,
  output logic                        o_tx_holding_ready,
  output logic                        o_rx_irq,
  output logic                        o_tx_irq,
  output logic [7:0]                  o_rx_data,
  output logic                        o_rx_valid,
  output logic [$clog2(DEPTH):0]      o_rx_count,
  output logic [$clog2(DEPTH):0]      o_tx_count
);
  localparam int unsigned CW = $clog2(DEPTH) + 1;
  localparam int unsigned BW = $clog2(BIT_CLKS);

  typedef enum logic [1:0] {
    RSTC_TX_IDLE = 2'b00,
    RSTC_TX_LOAD = 2'b01,
    RSTC_TX_SHIFT = 2'b10
  } rstc_txs_e;

  logic [1:0]       mode;
  rstc_txs_e        tx_state;
  logic [9:0]       tx_shift;
  logic [3:0]       tx_bits;
  logic [BW-1:0]    tx_tick;
  logic             tx_busy;
  logic [4:0]       tx_burst;
  logic             tx_pop;
  logic [7:0]       tx_head;
  logic             tx_empty;
  logic             tx_full;
  logic             next_drv;
  logic             next_rcv;
  logic             rx_s1;
  logic             rx_s2;
  logic [9:0]       rx_shift;
  logic [3:0]       rx_bits;
  logic [BW-1:0]    rx_tick;
  logic             rx_active;
  logic             rx_push;
  logic             rx_empty;
  logic             tx_accept;

  // mode register: immediate switch on write to offset 7
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= rstc_pkg::RSTC_MODE_RESET;
    end else if (i_wr && i_addr == rstc_pkg::RSTC_MODE_OFFSET) begin
      mode <= i_wdata[1:0];
    end
  end
  assign o_mode = mode;

  // fifo enable picks block mode or one byte at a time; no flush on change
  assign tx_accept = i_tx_push && !tx_full
                     && (i_fifo_en ? tx_burst != 5'h00 : tx_empty && !tx_busy);

  rstc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_clear (1'b0),
    .i_wr    (tx_accept),
    .i_wdata (i_tx_data),
    .i_rd    (tx_pop),
    .o_rdata (tx_head),
    .o_count (o_tx_count),
    .o_full  (tx_full),
    .o_empty (tx_empty)
  );

  rstc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_clear (1'b0),
    .i_wr    (rx_push),
    .i_wdata (rx_shift[8:1]),
    .i_rd    (i_rx_pop),
    .o_rdata (o_rx_data),
    .o_count (o_rx_count),
    .o_full  (),
    .o_empty (rx_empty)
  );

  // burst allowance reloads while the tx fifo is empty and the transmitter idle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_burst <= rstc_pkg::RSTC_TX_TRIG_RST;
      o_tx_irq <= 1'b0;
    end else begin
      o_tx_irq <= tx_empty && !tx_busy;
      if (tx_empty && !tx_busy) begin
        // the push that opens a block already uses one unit of it
        tx_burst <= (tx_accept && i_tx_trig != 5'h00)
                    ? i_tx_trig - 5'h01 : i_tx_trig;
      end else if (tx_accept && tx_burst != 5'h00) begin
        tx_burst <= tx_burst - 5'h01;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_irq <= 1'b0;
      o_rx_valid <= 1'b0;
    end else begin
      o_rx_irq <= i_fifo_en ? (o_rx_count >= CW'(i_rx_trig))
                            : !rx_empty;
      o_rx_valid <= i_rx_pop && !rx_empty;
    end
  end

  // transmitter; busy covers the last stop bit so auto drive holds
  assign tx_pop  = (tx_state == RSTC_TX_IDLE) && !tx_empty;
  assign tx_busy = (tx_state != RSTC_TX_IDLE);
  assign o_tx_holding_ready = tx_busy || !tx_empty;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state <= RSTC_TX_IDLE;
      tx_shift <= 10'h3ff;
      tx_bits  <= 4'h0;
      tx_tick  <= '0;
    end else begin
      case (tx_state)
        RSTC_TX_IDLE: begin
          if (!tx_empty) begin
            tx_state <= RSTC_TX_LOAD;
          end
        end
        RSTC_TX_LOAD: begin
          tx_shift <= {1'b1, tx_head, 1'b0};
          tx_bits  <= 4'(rstc_pkg::RSTC_FRAME_BITS);
          tx_tick  <= BW'(BIT_CLKS - 1);
          tx_state <= RSTC_TX_SHIFT;
        end
        RSTC_TX_SHIFT: begin
          if (tx_tick == '0) begin
            tx_tick  <= BW'(BIT_CLKS - 1);
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_bits  <= tx_bits - 4'h1;
            if (tx_bits == 4'h1) begin
              tx_state <= RSTC_TX_IDLE;
            end
          end else begin
            tx_tick <= tx_tick - 1'b1;
          end
        end
        default: tx_state <= RSTC_TX_IDLE;
      endcase
    end
  end
  assign o_txd = tx_shift[0];

  // receiver: two-stage sync, mid-bit sampling, gated by receiver enable
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= i_rxd;
      rx_s2 <= rx_s1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_active <= 1'b0;
      rx_shift  <= '0;
      rx_bits   <= 4'h0;
      rx_tick   <= '0;
      rx_push   <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (!rx_active) begin
        if (o_rcv_en && !rx_s2) begin
          rx_active <= 1'b1;
          // start already seen one clock in; this lands mid-bit
          rx_tick   <= BW'(BIT_CLKS / 2 - 1);
          rx_bits   <= 4'(rstc_pkg::RSTC_FRAME_BITS);
        end
      end else if (rx_tick == '0) begin
        rx_tick  <= BW'(BIT_CLKS - 1);
        rx_shift <= {rx_s2, rx_shift[9:1]};
        rx_bits  <= rx_bits - 4'h1;
        if (rx_bits == 4'h1) begin
          rx_active <= 1'b0;
          rx_push   <= rx_s2;
        end
      end else begin
        rx_tick <= rx_tick - 1'b1;
      end
    end
  end

  // direction decode; rs-232 builds keep both sides on
  always_comb begin
    next_drv = 1'b1;
    next_rcv = 1'b1;
    if (IS_RS485) begin
      case (mode)
        rstc_pkg::RSTC_MODE_FOUR_WIRE: begin
          next_drv = 1'b1;
          next_rcv = 1'b1;
        end
        rstc_pkg::RSTC_MODE_DTR_ECHO: begin
          next_drv = i_dtr_n;
          next_rcv = 1'b1;
        end
        rstc_pkg::RSTC_MODE_DTR_CTRL: begin
          next_drv = i_dtr_n;
          next_rcv = !i_dtr_n;
        end
        rstc_pkg::RSTC_MODE_AUTO: begin
          next_drv = o_tx_holding_ready;
          next_rcv = !o_tx_holding_ready;
        end
        default: begin
          next_drv = 1'b1;
          next_rcv = 1'b1;
        end
      endcase
    end
  end

  // registered so both enables change on one edge, no glitch
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_drv_en <= 1'b1;
      o_rcv_en <= 1'b1;
    end else begin
      o_drv_en <= next_drv;
      o_rcv_en <= next_rcv;
    end
  end

  chk_reset_mode: assert property (@(posedge i_mclk)
    $rose(i_rst_n) |-> o_mode == 2'h0) else $error("mode not four-wire");
  chk_four_wire: assert property (@(posedge i_mclk)
    disable iff (!i_rst_n) $past(mode) == 2'h0 |-> o_drv_en && o_rcv_en)
    else $error("four-wire enables off");
  chk_echo_drv: assert property (@(posedge i_mclk)
    disable iff (!i_rst_n)
    $past(mode) == 2'h1 |-> o_drv_en == $past(i_dtr_n))
    else $error("echo driver wrong");
  chk_echo_rcv: assert property (@(posedge i_mclk)
    disable iff (!i_rst_n) $past(mode) == 2'h1 |-> o_rcv_en)
    else $error("echo receiver off");
  chk_dtr_ctrl: assert property (@(posedge i_mclk)
    disable iff (!i_rst_n)
    $past(mode) == 2'h2 |-> o_rcv_en == !$past(i_dtr_n)
      && o_drv_en == $past(i_dtr_n))
    else $error("dtr control wrong");
  chk_auto_drv: assert property (@(posedge i_mclk)
    disable iff (!i_rst_n)
    $past(mode) == 2'h3 |-> o_drv_en == $past(o_tx_holding_ready))
    else $error("auto driver wrong");
  chk_auto_excl: assert property (@(posedge i_mclk)
    disable iff (!i_rst_n)
    $past(mode) == 2'h3 |-> o_rcv_en == !$past(o_tx_holding_ready)
      && !(o_drv_en && o_rcv_en))
    else $error("auto receiver wrong");
  chk_mode_write: assert property (@(posedge i_mclk)
    disable iff (!i_rst_n)
    i_wr && i_addr == 3'h7 |=> o_mode == $past(i_wdata[1:0]))
    else $error("mode write lost");
  // driver must cover every frame bit, stop bit included
  chk_stop_hold: assert property (@(posedge i_mclk)
    disable iff (!i_rst_n)
    mode == 2'h3 && $past(mode) == 2'h3 && tx_state != RSTC_TX_IDLE
      |-> o_drv_en)
    else $error("driver dropped early");
  chk_rx_trig: assert property (@(posedge i_mclk)
    disable iff (!i_rst_n)
    i_fifo_en && o_rx_count >= CW'(i_rx_trig) && $stable(i_fifo_en)
      |=> o_rx_irq || $past(o_rx_count) != o_rx_count)
    else $error("rx irq missing");

  cov_auto_send: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    mode == 2'h3 && $rose(o_drv_en));
  cov_echo_mode: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    mode == 2'h1 && $fell(o_drv_en));
  cov_rx_irq: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_rx_irq));
endmodule
`default_nettype wire

// ### testbench/rstc_peer_model.sv
// rstc_peer_model: rs-485 peer at the far end of the line.
// assumes 8n1 frames, lsb first, BIT_CLKS uart clocks per bit.
`timescale 1ns/1ps
`default_nettype none
module rstc_peer_model #(
  parameter int unsigned BIT_CLKS = 4
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_txd,
  input  wire logic       i_drv_en,
  input  wire logic       i_two_wire,
  input  wire logic       i_go,
  input  wire logic [7:0] i_byte,
  output logic            o_busy,
  output logic            o_rxd,
  output logic [7:0]      o_got,
  output logic            o_got_valid
);
  logic       bus;
  logic       peer_bit = 1'b1;
  logic       busy     = 1'b0;
  logic [9:0] frame;
  // failsafe bias pulls an undriven pair to mark
  assign bus    = i_drv_en ? i_txd : 1'b1;
  // one shared pair in two-wire: our own bits come back
  assign o_rxd  = i_two_wire ? (bus & peer_bit) : peer_bit;
  assign o_busy = busy;

  always @(posedge i_mclk) begin
    if (i_go) begin
      busy <= 1'b1;
      frame = {1'b1, i_byte, 1'b0};
      for (int b = 0; b < 10; b++) begin
        peer_bit <= frame[b];
        repeat (BIT_CLKS) @(posedge i_mclk);
      end
      busy <= 1'b0;
    end
  end

  // samples mid-bit; a frame with a low stop bit is dropped
  always @(posedge i_mclk) begin
    o_got_valid <= 1'b0;
    if (i_rst_n && bus == 1'b0) begin
      repeat (BIT_CLKS / 2) @(posedge i_mclk);
      for (int b = 0; b < 8; b++) begin
        repeat (BIT_CLKS) @(posedge i_mclk);
        o_got[b] <= bus;
      end
      repeat (BIT_CLKS) @(posedge i_mclk);
      o_got_valid <= (bus == 1'b1);
    end
  end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// testbench: self-checking bench for rstc_top with one rs-485 peer.
// assumes bit time shortened to 4 clocks; host rules kept by stimulus.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned BITC = 4;
  logic       i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_dtr_n = 1'b0;
  logic       i_fifo_en = 1'b1, i_tx_push = 1'b0, i_rx_pop = 1'b0;
  logic       i_rxd, two_wire = 1'b0, go = 1'b0, busy, got_valid;
  logic       drain = 1'b0, o_txd, o_drv_en, o_rcv_en, o_tx_holding_ready;
  logic       o_rx_irq, o_tx_irq, o_rx_valid;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00, i_tx_data = 8'h00, peer_byte = 8'h00;
  logic [7:0] got, o_rx_data;
  logic [4:0] i_rx_trig = 5'h01, i_tx_trig = 5'h10, o_rx_count, o_tx_count;
  logic [1:0] o_mode;
  logic [7:0] exp_tx[$], exp_rx[$];
  int         seed = 26918, miscompares = 0, samples_checked = 0;

  rstc_top #(.BIT_CLKS(BITC)) i_rstc_top (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_dtr_n(i_dtr_n), .i_fifo_en(i_fifo_en), .i_rx_trig(i_rx_trig),
    .i_tx_trig(i_tx_trig), .i_tx_push(i_tx_push), .i_tx_data(i_tx_data),
    .i_rx_pop(i_rx_pop), .i_rxd(i_rxd), .o_txd(o_txd),
    .o_drv_en(o_drv_en), .o_rcv_en(o_rcv_en), .o_mode(o_mode),
    .o_tx_holding_ready(o_tx_holding_ready), .o_rx_irq(o_rx_irq),
    .o_tx_irq(o_tx_irq), .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid),
    .o_rx_count(o_rx_count), .o_tx_count(o_tx_count));
  rstc_peer_model #(.BIT_CLKS(BITC)) i_rstc_peer_model (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_txd(o_txd), .i_drv_en(o_drv_en),
    .i_two_wire(two_wire), .i_go(go), .i_byte(peer_byte), .o_busy(busy),
    .o_rxd(i_rxd), .o_got(got), .o_got_valid(got_valid));

  always #5 i_mclk = ~i_mclk;

  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr_port(input logic [2:0] a, input logic [7:0] d);
    i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    tick();
    i_wr = 1'b0;
    tick(2);
  endtask
  // back-to-back pushes; only the first acc are expected on the line
  task automatic burst(input int n, input int acc, input bit echo);
    for (int k = 0; k < n; k++) begin
      i_tx_data = 8'($random(seed));
      i_tx_push = 1'b1;
      if (k < acc) exp_tx.push_back(i_tx_data);
      if (k < acc && echo) exp_rx.push_back(i_tx_data);
      tick();
    end
    i_tx_push = 1'b0;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (o_tx_holding_ready !== 1'b0 && k < 2000) begin
      tick();
      k++;
    end
    if (k >= 2000) miscompares++;
    tick(BITC * 3);
  endtask
  task automatic peer_send();
    int k;
    peer_byte = 8'($random(seed));
    exp_rx.push_back(peer_byte);
    go = 1'b1;
    tick();
    go = 1'b0;
    k = 0;
    while (busy === 1'b1 && k < 200) begin
      tick();
      k++;
    end
    if (k >= 200) miscompares++;
    tick(BITC);
  endtask
  function automatic logic [1:0] exp_en(input logic [1:0] m, input logic d);
    case (m)
      2'h0: return 2'b11;
      2'h1: return {d, 1'b1};
      2'h2: return {d, ~d};
      default: return 2'b01;
    endcase
  endfunction

  // results arrive in order; an unexpected one never matches
  always @(posedge i_mclk) begin
    if (got_valid === 1'b1)
      cmp_byte(got, exp_tx.size() ? exp_tx.pop_front() : ~got);
    if (o_rx_valid === 1'b1)
      cmp_byte(o_rx_data,
               exp_rx.size() ? exp_rx.pop_front() : ~o_rx_data);
  end
  // alternate pops so the registered count is seen settled
  always @(posedge i_mclk) begin
    #1;
    i_rx_pop = drain && !i_rx_pop && (o_rx_count != 5'h00);
  end

  initial begin
    repeat (2) @(posedge i_mclk);
    #1;
    i_rst_n = 1'b1;
    tick();
    cmp_byte({6'h00, o_mode}, 8'h00);
    cmp_byte({6'h00, o_drv_en, o_rcv_en}, 8'h03);
    for (int m = 0; m < 4; m++) begin
      wr_port(3'h7, {6'h15, 2'(m)});
      wr_port(3'h3, 8'h00);
      cmp_byte({6'h00, o_mode}, 8'(m));
      for (int d = 0; d < 2; d++) begin
        i_dtr_n = 1'(d);
        tick(2);
        cmp_byte({6'h00, o_drv_en, o_rcv_en},
                 {6'h00, exp_en(2'(m), 1'(d))});
      end
    end
    drain = 1'b1;
    two_wire = 1'b1;
    for (int m = 1; m < 3; m++) begin
      wr_port(3'h7, 8'(m));
      i_dtr_n = 1'b1;
      tick(2);
      burst(1, 1, m == 1);
      wait_idle();
      i_dtr_n = 1'b0;
      tick(2);
    end
    i_fifo_en = 1'b1;
    wr_port(3'h7, 8'h03);
    burst(3, 3, 1'b0);
    tick(6);
    cmp_byte({6'h00, o_drv_en, o_rcv_en}, 8'h02);
    cmp_byte({3'h0, o_tx_count}, 8'h02);
    cmp_bit(o_tx_irq, 1'b0);
    wait_idle();
    cmp_byte({6'h00, o_drv_en, o_rcv_en}, 8'h01);
    peer_send();
    two_wire = 1'b0;
    wr_port(3'h7, 8'h00);
    i_tx_trig = 5'h02;
    burst(3, 2, 1'b0);
    wait_idle();
    cmp_bit(o_tx_irq, 1'b1);
    i_fifo_en = 1'b0;
    burst(2, 1, 1'b0);
    wait_idle();
    i_fifo_en = 1'b1;
    drain = 1'b0;
    i_rx_trig = 5'h02;
    peer_send();
    cmp_bit(o_rx_irq, 1'b0);
    peer_send();
    cmp_bit(o_rx_irq, 1'b1);
    cmp_byte({3'h0, o_rx_count}, 8'h02);
    drain = 1'b1;
    tick(10);
    cmp_byte(8'(exp_tx.size() + exp_rx.size()), 8'h00);
    close_out();
  end

  initial begin
    #300000;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
